// *** include/e1_status_pkg.sv ***
// Shared constants and carrier types for the E1 event status and error counter bank.
// Assumes one 10 MHz clock and framer logic that delivers one-cycle event strobes on it.
package e1_status_pkg;

    // Register offsets on the parallel control port.
    localparam logic [7:0] OFS_VIOL_HIGH  = 8'h00;
    localparam logic [7:0] OFS_VIOL_LOW   = 8'h01;
    localparam logic [7:0] OFS_CRC_HIGH   = 8'h02;
    localparam logic [7:0] OFS_CRC_LOW    = 8'h03;
    localparam logic [7:0] OFS_EBIT_HIGH  = 8'h04;
    localparam logic [7:0] OFS_EBIT_LOW   = 8'h05;
    localparam logic [7:0] OFS_RX_ALARM   = 8'h06;
    localparam logic [7:0] OFS_EVENT      = 8'h07;
    localparam logic [7:0] OFS_ALARM_MASK = 8'h16;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h17;

    // Value after reset of every status, mask and read-data register.
    localparam logic [7:0] REG_RESET      = 8'h00;
    // Value returned for an unmapped address.
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

    // Bit positions inside the event status and event mask registers.
    localparam int BIT_RX_SIG_MF    = 7;
    localparam int BIT_RX_ALIGN     = 6;
    localparam int BIT_TX_MF        = 5;
    localparam int BIT_INTERVAL     = 4;
    localparam int BIT_TX_ALIGN     = 3;
    localparam int BIT_TX_CLK_LOST  = 2;
    localparam int BIT_RX_CRC_MF    = 1;
    localparam int BIT_TX_SLIP      = 0;

    // Receive frames are 125 us apart: 8000 make one second, 500 make 62.5 ms.
    localparam int             FRAME_CNT_W      = 13;
    localparam logic [12:0]    FRAMES_PER_SEC   = 13'd8000;
    localparam logic [12:0]    FRAMES_PER_FAST  = 13'd500;

    // One channel time of silence on the transmit clock, counted in mclk cycles.
    localparam int             MCLK_PERIOD_NS   = 100;
    localparam int             CLOCK_LOSS_NS    = 3900;
    localparam int             CLOCK_LOSS_W     = 6;
    localparam logic [5:0]     CLOCK_LOSS_CYCLES =
        6'((CLOCK_LOSS_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

    // Counter widths.
    localparam int VIOL_W = 16;
    localparam int CRC_W  = 10;
    localparam int EBIT_W = 10;
    localparam int FAS_W  = 12;

    // One-cycle event strobes from the framer and elastic stores.
    typedef struct packed {
        logic rx_sig_mf;
        logic rx_align;
        logic tx_mf;
        logic tx_align;
        logic rx_crc_mf;
        logic tx_slip;
    } framer_events_s;

    // Received line symbols, one strobe per bit time.
    typedef struct packed {
        logic bit_strobe;
        logic pos_mark;
        logic neg_mark;
    } line_code_s;

    // Error strobes and alignment levels from the receive framer.
    typedef struct packed {
        logic crc_word_error;
        logic fas_word_error;
        logic ebit_strobe;
        logic ebit_value;
        logic fas_sync_lost;
        logic crc_sync_lost;
    } rx_errors_s;

    // Control bits held elsewhere in the device.
    typedef struct packed {
        logic fast_interval_select;
        logic violation_type_select;
        logic rx_hdb3_enable;
        logic clock_loss_output_enable;
        logic crc4_enable;
    } control_s;

endpackage

// *** test/e1_event_status_asserts.sv ***
// Checker for the event status bank, watching only its top-level ports.
// Assumes a single reset at the start and the bench's host access pattern.
`timescale 1ns/1ps
module e1_event_status_asserts
    import e1_status_pkg::*;
(
    input wire logic           mclk,
    input wire logic           rst,
    input wire logic [7:0]     host_addr,
    input wire logic [7:0]     host_wdata,
    input wire logic           host_rd,
    input wire logic           host_wr,
    input wire logic [7:0]     host_rdata,
    input wire logic           irq,
    input wire logic           clock_lost_out,
    input wire logic           tx_clock_input,
    input wire framer_events_s events,
    input wire control_s       control
);
    logic       tx_prev;
    logic [5:0] quiet_cnt;

    // Counts cycles since the transmit clock pin last changed, saturating.
    always_ff @(posedge mclk) begin
        tx_prev   <= tx_clock_input;
        quiet_cnt <= (rst || tx_clock_input != tx_prev) ? 6'h00 :
                     (quiet_cnt == 6'h3F) ? quiet_cnt : quiet_cnt + 6'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Register port, status and clock-loss relations.
    property p_reset_quiet;
        $fell(rst) |-> host_rdata == REG_RESET && !irq && !clock_lost_out;
    endproperty
    property p_rdata_holds;
        !host_rd |=> $stable(host_rdata);
    endproperty
    property p_mask_back;
        host_wr && host_addr == OFS_EVENT_MASK ##1 host_rd && host_addr == OFS_EVENT_MASK
            |=> host_rdata == $past(host_wdata, 2);
    endproperty
    property p_read_clears;
        host_rd && host_addr == OFS_EVENT && events == '0 ##1
            host_rd && host_addr == OFS_EVENT |=> (host_rdata & 8'hEB) == 8'h00;
    endproperty
    property p_slip_seen;
        events.tx_slip ##1 host_rd && host_addr == OFS_EVENT |=> host_rdata[BIT_TX_SLIP];
    endproperty
    property p_masks_off;
        host_wr && host_addr == OFS_EVENT_MASK && host_wdata == 8'h00 ##1
            host_wr && host_addr == OFS_ALARM_MASK && host_wdata == 8'h00 |=> ##1 !irq;
    endproperty
    property p_pin_off;
        !control.clock_loss_output_enable |=> !clock_lost_out;
    endproperty
    property p_loss_not_early;
        quiet_cnt == 6'd38 |-> !clock_lost_out;
    endproperty
    property p_loss_seen;
        quiet_cnt == 6'd46 && control.clock_loss_output_enable |-> clock_lost_out;
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not idle after reset");
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data moved without read");
    a_mask_back: assert property (p_mask_back)
        else $error("event mask read back wrong");
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared by read");
    a_slip_seen: assert property (p_slip_seen)
        else $error("slip flag not latched");
    a_masks_off: assert property (p_masks_off)
        else $error("irq with all masks clear");
    a_pin_off: assert property (p_pin_off)
        else $error("loss pin high while disabled");
    a_loss_not_early: assert property (p_loss_not_early)
        else $error("loss flagged early");
    a_loss_seen: assert property (p_loss_seen)
        else $error("loss of clock not flagged");

    c_irq: cover property (irq);
    c_loss: cover property (clock_lost_out);
    c_two_reads: cover property (host_rd && host_addr == OFS_EVENT ##1 host_rd);
endmodule

bind e1_event_status e1_event_status_asserts e1_event_status_asserts_i (
    .mclk(mclk), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rd(host_rd), .host_wr(host_wr), .host_rdata(host_rdata), .irq(irq),
    .clock_lost_out(clock_lost_out), .tx_clock_input(tx_clock_input),
    .events(events), .control(control));

// *** test/host_model.sv ***
// Host processor model making one register access per mclk cycle.
// Assumes the design takes host strobes on the rising edge of mclk.
`timescale 1ns/1ps
module host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] host_rdata,
    output logic      [7:0] host_addr,
    output logic      [7:0] host_wdata,
    output logic            host_rd,
    output logic            host_wr
);
    // The bus starts idle with no strobe raised.
    initial begin
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = 8'h00;
        host_wdata = 8'h00;
    end

    // Raises one strobe at a falling edge and takes the answer one cycle on.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v,
                       output logic [7:0] rdat);
        host_wr    = w;
        host_rd    = !w;
        host_addr  = a;
        host_wdata = v;
        @(negedge mclk);
        rdat = host_rdata;
    endtask

    // Drops the strobes and inverts the released lines so no stale value lingers.
    task automatic idle;
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = ~host_addr;
        host_wdata = ~host_wdata;
        @(negedge mclk);
    endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the event status bank, driven through a host model.
// Assumes a 10 MHz mclk with every input changed on its falling edge.
`timescale 1ns/1ps
module tb_top
    import e1_status_pkg::*;
;
    logic           mclk = 1'b0, rst = 1'b1, tx_run = 1'b1, tx_clk = 1'b0, frame = 1'b0;
    logic           tx_half = 1'b0;
    logic [7:0]     alarms = 8'h00, d;
    framer_events_s events = '0;
    line_code_s     line = '0;
    rx_errors_s     errors = '0;
    control_s       control = '0;
    wire  [7:0]     host_addr, host_wdata, host_rdata;
    wire            host_rd, host_wr, irq, clock_lost_out;
    int             err_total = 0, comparisons = 0, n;
    logic [7:0]     map [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                 8'h16, 8'h17, 8'h20};
    int             pos [6] = '{BIT_TX_SLIP, BIT_RX_CRC_MF, BIT_TX_ALIGN, BIT_TX_MF,
                                BIT_RX_ALIGN, BIT_RX_SIG_MF};

    // Main clock, and a transmit clock at a quarter of mclk while enabled; toggling every
    // cycle would be too fast for the three-stage synchroniser to see two agreeing samples.
    always #50 mclk = ~mclk;
    always @(negedge mclk) if (tx_run) {tx_clk, tx_half} <= {tx_clk ^ tx_half, ~tx_half};

    host_model host_model_i (.mclk(mclk), .host_rdata(host_rdata), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr));
    e1_event_status e1_event_status_i (.mclk(mclk), .rst(rst), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
        .host_rdata(host_rdata), .irq(irq), .clock_lost_out(clock_lost_out),
        .tx_clock_input(tx_clk), .rx_frame_strobe(frame), .events(events), .line(line),
        .errors(errors), .rx_alarm_status(alarms), .control(control));

    // Comparison, access and wait helpers.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host_model_i.acc(1'b0, a, 8'h00, d);
        chk(16'(d), 16'(exp), $sformatf("register %h", a));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_model_i.acc(1'b1, a, v, d);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // Drives the marks negative, positive, positive, negative, negative, one per cycle.
    task automatic marks;
        for (int i = 0; i < 5; i++) begin
            line = line_code_s'({1'b1, i == 1 || i == 2, i == 0 || i > 2});
            cyc(1);
        end
        line = '0;
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1) begin
            if (n == 2000) begin
                err_total++;
                end_of_test();
            end
            cyc(1);
            n++;
        end
    endtask

    initial begin
        cyc(20);
        rst = 1'b0;
        // Every register, and an unmapped offset, reads zero after reset.
        for (int i = 0; i < 11; i++) rd(map[i], REG_RESET);
        wr(OFS_EVENT, 8'hFF);
        wr(OFS_ALARM_MASK, 8'hA5);
        rd(OFS_ALARM_MASK, 8'hA5);
        wr(OFS_EVENT_MASK, 8'h5A);
        rd(OFS_EVENT_MASK, 8'h5A);
        rd(OFS_EVENT, 8'h00);
        wr(OFS_EVENT_MASK, 8'h00);
        wr(OFS_ALARM_MASK, 8'h00);
        host_model_i.idle();
        // Each framer event sets its own status bit until the status is read.
        for (int i = 0; i < 6; i++) begin
            events = framer_events_s'(6'h01 << i);
            cyc(1);
            events = '0;
            rd(OFS_EVENT, 8'h01 << pos[i]);
            rd(OFS_EVENT, 8'h00);
            host_model_i.idle();
        end
        // A latched flag interrupts only once its mask bit is set.
        events.tx_slip = 1'b1;
        cyc(1);
        events = '0;
        cyc(2);
        chk(16'(irq), 16'h0000, "irq masked");
        wr(OFS_EVENT_MASK, 8'h01);
        host_model_i.idle();
        cyc(1);
        chk(16'(irq), 16'h0001, "irq set");
        rd(OFS_EVENT, 8'h01);
        host_model_i.idle();
        cyc(1);
        chk(16'(irq), 16'h0000, "irq cleared");
        // A standing loss of sync keeps its alarm bit set across reads.
        alarms = 8'h01;
        wr(OFS_ALARM_MASK, 8'h01);
        host_model_i.idle();
        cyc(1);
        chk(16'(irq), 16'h0001, "irq alarm");
        rd(OFS_RX_ALARM, 8'h01);
        rd(OFS_RX_ALARM, 8'h01);
        host_model_i.idle();
        alarms = 8'h00;
        cyc(2);
        rd(OFS_RX_ALARM, 8'h01);
        rd(OFS_RX_ALARM, 8'h00);
        wr(OFS_EVENT_MASK, 8'h00);
        wr(OFS_ALARM_MASK, 8'h00);
        host_model_i.idle();
        // A stopped transmit clock sets the loss flag and drives the pin.
        control.clock_loss_output_enable = 1'b1;
        tx_run <= 1'b0;
        cyc(60);
        chk(16'(clock_lost_out), 16'h0001, "loss pin");
        rd(OFS_EVENT, 8'h04);
        host_model_i.idle();
        tx_run <= 1'b1;
        cyc(10);
        rd(OFS_EVENT, 8'h04);
        rd(OFS_EVENT, 8'h00);
        host_model_i.idle();
        chk(16'(clock_lost_out), 16'h0000, "loss pin");
        // Errors of one fast interval, some while unaligned, land split across registers.
        control.fast_interval_select = 1'b1;
        control.crc4_enable = 1'b1;
        errors = rx_errors_s'(6'b000011);
        marks();
        for (int i = 0; i < 6; i++) begin
            errors = rx_errors_s'({i < 3, i < 5, 1'b1, i > 3, 2'b00});
            cyc(1);
        end
        errors = rx_errors_s'(6'b100101);
        cyc(1);
        errors = '0;
        wr(OFS_EVENT_MASK, 8'h10);
        host_model_i.idle();
        frame = 1'b1;
        wait_irq();
        frame = 1'b0;
        chk(16'(n), 16'(FRAMES_PER_FAST), "interval");
        rd(OFS_VIOL_HIGH, 8'h00);
        rd(OFS_VIOL_LOW, 8'h02);
        rd(OFS_CRC_HIGH, 8'h00);
        rd(OFS_CRC_LOW, 8'h03);
        rd(OFS_EBIT_HIGH, 8'h14);
        rd(OFS_EBIT_LOW, 8'h04);
        rd(OFS_EVENT, 8'h10);
        host_model_i.idle();
        // Code violation mode, then bipolar mode with HDB3: only the first violation of the
        // pattern repeats the polarity of the violation before it, so each interval holds one.
        control.violation_type_select = 1'b1;
        for (int k = 0; k < 2; k++) begin
            marks();
            frame = 1'b1;
            wait_irq();
            frame = 1'b0;
            chk(16'(n), 16'(FRAMES_PER_FAST), "interval");
            rd(OFS_VIOL_LOW, 8'h01);
            rd(OFS_EVENT, 8'h10);
            host_model_i.idle();
            control.violation_type_select = 1'b0;
            control.rx_hdb3_enable = 1'b1;
        end
        // A quiet interval replaces the previous totals.
        frame = 1'b1;
        wait_irq();
        frame = 1'b0;
        rd(OFS_VIOL_LOW, 8'h00);
        host_model_i.idle();
        end_of_test();
    end
endmodule

// *** verilog/e1_event_status.sv ***
// Event status flags, interrupt masks and interval error counters of an E1 transceiver.
// Assumes framer strobes arrive on mclk and the host port strobes are synchronous to mclk.
`timescale 1ns/1ps
// Notes on behaviour
// - Receive signaling multiframe flag every multiframe
// - Receive align-frame flag at each align frame
// - Transmit multiframe flag every transmit multiframe
// - Interval flag each second or 62.5 ms
// - Transmit align-frame flag every 250 us
// - Clock-lost flag after one silent channel time
// - CRC multiframe flag, free-running without CRC4
// - Transmit slip flag on frame repeat/drop
// - Per-bit mask for receive alarm status
// - Per-bit mask for event status
// - Counts transfer to registers each interval
// - Type 0 counts BPVs, skipping HDB3 codes
// - Type 1 counts code violations
// - Violations always counted, saturating at 65535
// - Violation count high byte 0x00, low 0x01
// - CRC count split, FAS top bits above
// - CRC and E-bit counts stop without alignment
// - E-bit count increments on received zero
// - E-bit count split across two registers
// - Sync-lost status set while unaligned
module e1_event_status
    import e1_status_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic [7:0]     host_addr,
    input  wire logic [7:0]     host_wdata,
    input  wire logic           host_rd,
    input  wire logic           host_wr,
    output logic      [7:0]     host_rdata,
    output logic                irq,
    output logic                clock_lost_out,
    input  wire logic           tx_clock_input,
    input  wire logic           rx_frame_strobe,
    input  wire framer_events_s events,
    input  wire line_code_s     line,
    input  wire rx_errors_s     errors,
    input  wire logic [7:0]     rx_alarm_status,
    input  wire control_s       control
);

    typedef struct packed {
        logic [7:0]             rx_alarm;
        logic [7:0]             event_status;
        logic [7:0]             alarm_mask;
        logic [7:0]             event_mask;
        logic [7:0]             rdata;
        logic                   irq;
        logic                   clock_lost_pin;
        logic [FRAME_CNT_W-1:0] frame_cnt;
        logic                   seen_mark;
        logic                   last_mark_neg;
        logic                   last_viol_neg;
    } bank_state_s;

    bank_state_s        state;
    bank_state_s        next_state;
    logic               interval_end;
    logic [12:0]        frame_limit;
    logic               clock_lost;
    logic               bpv;
    logic               viol_inc;
    logic               crc_inc;
    logic               fas_inc;
    logic               ebit_inc;
    logic               crc_aligned;
    logic [7:0]         event_set;
    logic [7:0]         alarm_set;
    logic [VIOL_W-1:0]  viol_held;
    logic [CRC_W-1:0]   crc_held;
    logic [EBIT_W-1:0]  ebit_held;
    logic [FAS_W-1:0]   fas_held;

    // Interval timer paced by received frames; its end latches all counters.
    assign frame_limit  = control.fast_interval_select ? FRAMES_PER_FAST
                                                       : FRAMES_PER_SEC;
    assign interval_end = rx_frame_strobe
                       && (state.frame_cnt >= frame_limit - 13'd1);

    // Line code violation detection for both counting modes.
    assign bpv      = line.bit_strobe && (line.pos_mark || line.neg_mark) && state.seen_mark
                   && (line.neg_mark == state.last_mark_neg);
    assign viol_inc = control.violation_type_select
                    ? (bpv && (line.neg_mark == state.last_viol_neg))
                    : (bpv && (!control.rx_hdb3_enable
                               || (line.neg_mark == state.last_viol_neg)));

    // CRC and E-bit counting needs both frame and CRC multiframe alignment.
    assign crc_aligned = !errors.fas_sync_lost && !errors.crc_sync_lost;
    assign crc_inc     = errors.crc_word_error && crc_aligned;
    assign ebit_inc    = errors.ebit_strobe && !errors.ebit_value
                      && control.crc4_enable && crc_aligned;
    assign fas_inc     = errors.fas_word_error && !errors.fas_sync_lost;

    // Events that set the sticky flags this cycle.
    always_comb begin
        event_set                  = 8'h00;
        event_set[BIT_RX_SIG_MF]   = events.rx_sig_mf;
        event_set[BIT_RX_ALIGN]    = events.rx_align;
        event_set[BIT_TX_MF]       = events.tx_mf;
        event_set[BIT_INTERVAL]    = interval_end;
        event_set[BIT_TX_ALIGN]    = events.tx_align;
        event_set[BIT_TX_CLK_LOST] = clock_lost;
        event_set[BIT_RX_CRC_MF]   = events.rx_crc_mf;
        event_set[BIT_TX_SLIP]     = events.tx_slip;
        alarm_set                  = rx_alarm_status;
    end

    // Next-state logic for flags, masks, read data, interrupt and line tracking.
    always_comb begin
        next_state = state;
        // Flags stay set until a status read; a set in the read cycle wins.
        if (host_rd && host_addr == OFS_EVENT) begin
            next_state.event_status = event_set;
        end else begin
            next_state.event_status = state.event_status | event_set;
        end
        if (host_rd && host_addr == OFS_RX_ALARM) begin
            next_state.rx_alarm = alarm_set;
        end else begin
            next_state.rx_alarm = state.rx_alarm | alarm_set;
        end
        // Mask writes.
        if (host_wr && host_addr == OFS_ALARM_MASK) begin
            next_state.alarm_mask = host_wdata;
        end
        if (host_wr && host_addr == OFS_EVENT_MASK) begin
            next_state.event_mask = host_wdata;
        end
        // Read data shows the value before any clear caused by this read.
        if (host_rd) begin
            case (host_addr)
                OFS_VIOL_HIGH:  next_state.rdata = viol_held[15:8];
                OFS_VIOL_LOW:   next_state.rdata = viol_held[7:0];
                OFS_CRC_HIGH:   next_state.rdata = {fas_held[11:6], crc_held[9:8]};
                OFS_CRC_LOW:    next_state.rdata = crc_held[7:0];
                OFS_EBIT_HIGH:  next_state.rdata = {fas_held[5:0], ebit_held[9:8]};
                OFS_EBIT_LOW:   next_state.rdata = ebit_held[7:0];
                OFS_RX_ALARM:   next_state.rdata = state.rx_alarm;
                OFS_EVENT:      next_state.rdata = state.event_status;
                OFS_ALARM_MASK: next_state.rdata = state.alarm_mask;
                OFS_EVENT_MASK: next_state.rdata = state.event_mask;
                default:        next_state.rdata = UNMAPPED_DATA;
            endcase
        end
        // Interrupt follows the flags and masks that take effect next cycle.
        next_state.irq = |(next_state.event_status & next_state.event_mask)
                      || |(next_state.rx_alarm & next_state.alarm_mask);
        next_state.clock_lost_pin = clock_lost && control.clock_loss_output_enable;
        // Interval frame counter.
        if (interval_end) begin
            next_state.frame_cnt = '0;
        end else if (rx_frame_strobe) begin
            next_state.frame_cnt = state.frame_cnt + 13'd1;
        end
        // Polarity history of marks and violations.
        if (line.bit_strobe && (line.pos_mark || line.neg_mark)) begin
            next_state.seen_mark     = 1'b1;
            next_state.last_mark_neg = line.neg_mark;
        end
        if (bpv) begin
            next_state.last_viol_neg = line.neg_mark;
        end
    end

    // Registers the bank state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Transmit clock watchdog.
    tx_clock_monitor u_tx_clock_monitor (
        .mclk           (mclk),
        .rst            (rst),
        .tx_clock_input (tx_clock_input),
        .clock_lost     (clock_lost)
    );

    // Violation counter runs regardless of alignment and saturates.
    error_counter #(.WIDTH(VIOL_W), .SATURATE(1'b1)) u_viol_counter (
        .mclk  (mclk),
        .rst   (rst),
        .inc   (viol_inc),
        .latch (interval_end),
        .held  (viol_held)
    );

    // CRC word error counter.
    error_counter #(.WIDTH(CRC_W), .SATURATE(1'b0)) u_crc_counter (
        .mclk  (mclk),
        .rst   (rst),
        .inc   (crc_inc),
        .latch (interval_end),
        .held  (crc_held)
    );

    // Far-end block error counter.
    error_counter #(.WIDTH(EBIT_W), .SATURATE(1'b0)) u_ebit_counter (
        .mclk  (mclk),
        .rst   (rst),
        .inc   (ebit_inc),
        .latch (interval_end),
        .held  (ebit_held)
    );

    // Framing word error counter, shown beside the CRC and E-bit counts.
    error_counter #(.WIDTH(FAS_W), .SATURATE(1'b0)) u_fas_counter (
        .mclk  (mclk),
        .rst   (rst),
        .inc   (fas_inc),
        .latch (interval_end),
        .held  (fas_held)
    );

    assign host_rdata     = state.rdata;
    assign irq            = state.irq;
    assign clock_lost_out = state.clock_lost_pin;

endmodule

// *** verilog/error_counter.sv ***
// Counts error strobes during an interval and hands the total to a readable holding register.
// Assumes the latch strobe and the count strobe are one-cycle pulses on mclk.
`timescale 1ns/1ps
module error_counter
    import e1_status_pkg::*;
#(
    parameter int WIDTH    = 10,
    parameter bit SATURATE = 1'b0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             inc,
    input  wire logic             latch,
    output logic      [WIDTH-1:0] held
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic [WIDTH-1:0] held;
    } cnt_state_s;

    cnt_state_s state;
    cnt_state_s next_state;
    logic       at_max;

    // An error arriving with the latch starts the new interval, so nothing is lost.
    always_comb begin
        next_state = state;
        at_max     = &state.count;
        if (latch) begin
            next_state.held  = state.count;
            next_state.count = WIDTH'(inc);
        end else if (inc && !(SATURATE && at_max)) begin
            next_state.count = state.count + WIDTH'(1);
        end
    end

    // Registers the counter state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign held = state.held;

endmodule

// *** verilog/tx_clock_monitor.sv ***
// Watches the transmit clock pin and reports when it has stopped toggling.
// Assumes the pin is asynchronous to mclk; it is synchronised through three flip-flops.
`timescale 1ns/1ps
module tx_clock_monitor
    import e1_status_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic tx_clock_input,
    output logic      clock_lost
);

    typedef struct packed {
        logic [2:0]              sync;
        logic                    level;
        logic [CLOCK_LOSS_W-1:0] idle;
        logic                    lost;
    } mon_state_s;

    mon_state_s state;
    mon_state_s next_state;
    logic       edge_seen;

    // A transition counts once the second and third stages agree on a new level.
    always_comb begin
        next_state      = state;
        next_state.sync = {state.sync[1:0], tx_clock_input};
        edge_seen       = (state.sync[1] == state.sync[2]) && (state.sync[2] != state.level);
        if (edge_seen) begin
            next_state.level = state.sync[2];
            next_state.idle  = '0;
            next_state.lost  = 1'b0;
        end else if (state.idle >= CLOCK_LOSS_CYCLES - 6'd1) begin
            next_state.lost  = 1'b1;
        end else begin
            next_state.idle  = state.idle + 6'd1;
        end
    end

    // Registers the monitor state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clock_lost = state.lost;

endmodule
